/* File: hdl/ssh_pkg.sv */
// shared constants, types and helpers for the sync sram host port
package ssh_pkg;
   // ================================================================
   // widths
   localparam int unsigned DATA_W = 36;
   localparam int unsigned BYTE_W = 9;
   localparam int unsigned NBYTES = 4;
   localparam int unsigned ADDR_W = 21;
   // words actually stored by the device end, burst pairs included
   localparam int unsigned MEM_AW = 10;
   localparam int unsigned MEM_DEPTH = 1 << MEM_AW;

   typedef logic [DATA_W-1:0] ssh_word_t;
   typedef logic [ADDR_W-1:0] ssh_addr_t;
   typedef logic [NBYTES-1:0] ssh_bmask_t;

   // ================================================================
   // timing
   localparam int unsigned CORE_PERIOD_NS = 20;
   localparam int unsigned K_PHASES = 4;
   localparam int unsigned K_PERIOD_NS = CORE_PERIOD_NS * K_PHASES;
   localparam int unsigned PLL_LOCK_NS = 20000;
   localparam int unsigned LOCK_W = 12;
   localparam logic [LOCK_W-1:0] PLL_LOCK_CYC =
      LOCK_W'((PLL_LOCK_NS + K_PERIOD_NS - 1) / K_PERIOD_NS);

   // ================================================================
   // link clock phase, gray along the cycle
   typedef enum logic [1:0] {
      SSH_PH0 = 2'h0,
      SSH_PH1 = 2'h1,
      SSH_PH2 = 2'h3,
      SSH_PH3 = 2'h2
   } ssh_phase_e;

   // ================================================================
   // byte-masked merge, strobes active low
   function automatic ssh_word_t byte_merge(ssh_word_t old_w, ssh_word_t new_w, ssh_bmask_t bs_n);
      ssh_word_t res;
      res = old_w;
      for (int i = 0; i < NBYTES; i++) begin
         if (!bs_n[i]) begin
            res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
         end
      end
      return res;
   endfunction
endpackage

/* File: hdl/ssh_link_if.sv */
// link between the memory controller end and the sram device end
`timescale 1ns/10ps
`default_nettype none
interface ssh_link_if;
   logic in_clk;
   logic in_clk_n;
   logic rd_sel_n;
   logic wr_sel_n;
   ssh_pkg::ssh_addr_t shared_addr_lines;
   ssh_pkg::ssh_word_t wr_data;
   ssh_pkg::ssh_bmask_t byte_strobe_n;
   logic pll_bypass_n;
   ssh_pkg::ssh_word_t rd_data;
   logic rd_data_oe;
   logic output_valid_flag;
   logic echo_strobe;
   logic echo_strobe_n;

   modport dev (
      input in_clk,
      input in_clk_n,
      input rd_sel_n,
      input wr_sel_n,
      input shared_addr_lines,
      input wr_data,
      input byte_strobe_n,
      input pll_bypass_n,
      output rd_data,
      output rd_data_oe,
      output output_valid_flag,
      output echo_strobe,
      output echo_strobe_n
   );

   modport ctl (
      output in_clk,
      output in_clk_n,
      output rd_sel_n,
      output wr_sel_n,
      output shared_addr_lines,
      output wr_data,
      output byte_strobe_n,
      output pll_bypass_n,
      input rd_data,
      input rd_data_oe,
      input output_valid_flag,
      input echo_strobe,
      input echo_strobe_n
   );
endinterface
`default_nettype wire

/* File: hdl/ssh_sram_ctl.sv */
// controller end: makes the input clock pair, issues bursts, collects reads
`timescale 1ns/10ps
`default_nettype none
module ssh_sram_ctl (
   ssh_link_if.ctl lnk,
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pll_bypass_req,
   input wire logic rd_valid,
   input wire ssh_pkg::ssh_addr_t rd_addr,
   input wire logic wr_valid,
   input wire ssh_pkg::ssh_addr_t wr_addr,
   input wire ssh_pkg::ssh_word_t wr_data0,
   input wire ssh_pkg::ssh_word_t wr_data1,
   input wire ssh_pkg::ssh_bmask_t wr_be0,
   input wire ssh_pkg::ssh_bmask_t wr_be1,
   output logic req_ready,
   output logic rsp_valid,
   output ssh_pkg::ssh_word_t rsp_data0,
   output ssh_pkg::ssh_word_t rsp_data1
);
   localparam ssh_pkg::ssh_bmask_t NO_BYTES = {ssh_pkg::NBYTES{1'b1}};

   // ================================================================
   // clock divider: k high in ph1 and ph2, /k rises entering ph3
   ssh_pkg::ssh_phase_e ph_r, ph_nxt;
   logic k_r, kn_r;

   always_comb begin
      unique case (ph_r)
         ssh_pkg::SSH_PH0: ph_nxt = ssh_pkg::SSH_PH1;
         ssh_pkg::SSH_PH1: ph_nxt = ssh_pkg::SSH_PH2;
         ssh_pkg::SSH_PH2: ph_nxt = ssh_pkg::SSH_PH3;
         ssh_pkg::SSH_PH3: ph_nxt = ssh_pkg::SSH_PH0;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ph_r <= ssh_pkg::SSH_PH0;
         k_r <= 1'b0;
         kn_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         k_r <= (ph_nxt == ssh_pkg::SSH_PH1) || (ph_nxt == ssh_pkg::SSH_PH2);
         kn_r <= !((ph_nxt == ssh_pkg::SSH_PH1) || (ph_nxt == ssh_pkg::SSH_PH2));
      end
   end

   assign lnk.in_clk = k_r;
   assign lnk.in_clk_n = kn_r;

   // ================================================================
   // command launch: k-edge fields change entering ph0, /k fields entering ph2
   logic rd_sel_n_r, wr_sel_n_r, wr_hold_r, byp_n_r;
   ssh_pkg::ssh_addr_t addr_r, wr_addr_hold_r;
   ssh_pkg::ssh_word_t d_r, d1_hold_r;
   ssh_pkg::ssh_bmask_t bs_n_r, bs1_hold_r;

   assign req_ready = (ph_r == ssh_pkg::SSH_PH3);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rd_sel_n_r <= 1'b1;
         wr_sel_n_r <= 1'b1;
         wr_hold_r <= 1'b0;
         addr_r <= '0;
         wr_addr_hold_r <= '0;
         d_r <= '0;
         d1_hold_r <= '0;
         bs_n_r <= NO_BYTES;
         bs1_hold_r <= NO_BYTES;
      end else if (ph_r == ssh_pkg::SSH_PH3) begin
         rd_sel_n_r <= !rd_valid;
         wr_sel_n_r <= !wr_valid;
         wr_hold_r <= wr_valid;
         if (rd_valid) begin
            addr_r <= rd_addr;
         end
         wr_addr_hold_r <= wr_addr;
         d_r <= wr_data0;
         d1_hold_r <= wr_data1;
         bs_n_r <= wr_valid ? ~wr_be0 : NO_BYTES;
         bs1_hold_r <= wr_valid ? ~wr_be1 : NO_BYTES;
      end else if (ph_r == ssh_pkg::SSH_PH1) begin
         if (wr_hold_r) begin
            addr_r <= wr_addr_hold_r;
         end
         d_r <= d1_hold_r;
         bs_n_r <= bs1_hold_r;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         byp_n_r <= 1'b0;
      end else begin
         byp_n_r <= !pll_bypass_req;
      end
   end

   assign lnk.rd_sel_n = rd_sel_n_r;
   assign lnk.wr_sel_n = wr_sel_n_r;
   assign lnk.shared_addr_lines = addr_r;
   assign lnk.wr_data = d_r;
   assign lnk.byte_strobe_n = bs_n_r;
   assign lnk.pll_bypass_n = byp_n_r;

   // ================================================================
   // read capture, sampled mid-phase where the returned word is steady
   logic vld_s_r, got0_r, rsp_valid_r;
   ssh_pkg::ssh_word_t rsp_d0_r, rsp_d1_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         vld_s_r <= 1'b0;
         got0_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_d0_r <= '0;
         rsp_d1_r <= '0;
      end else begin
         rsp_valid_r <= 1'b0;
         if (ph_r == ssh_pkg::SSH_PH3) begin
            vld_s_r <= lnk.output_valid_flag;
            rsp_valid_r <= got0_r;
            got0_r <= 1'b0;
            if (got0_r) begin
               rsp_d1_r <= lnk.rd_data;
            end
         end else if (ph_r == ssh_pkg::SSH_PH1) begin
            got0_r <= vld_s_r;
            if (vld_s_r) begin
               rsp_d0_r <= lnk.rd_data;
            end
         end
      end
   end

   assign rsp_valid = rsp_valid_r;
   assign rsp_data0 = rsp_d0_r;
   assign rsp_data1 = rsp_d1_r;
endmodule // ssh_sram_ctl
`default_nettype wire

/* File: hdl/ssh_sram_dev.sv */
// device end: two-word burst sram with separate read and write ports
//
// How it works
// - read address at k, write address at /k
// - address ignored while neither port is selected
// - read select low at k starts read when pll_ready is high
// - write select low at k starts write
// - only strobed-low bytes are written
// - strobes travel with each of two words
// - control at k, data at k and /k
// - bypass input low skips pll lock wait
// - valid flag leads data by half cycle
// - echo clocks toggle always, even when idle
`timescale 1ns/10ps
`default_nettype none
module ssh_sram_dev (
   ssh_link_if.dev lnk,
   input wire logic nrst,
   output logic pll_active,
   output logic pll_ready
);
   localparam ssh_pkg::ssh_bmask_t NO_BYTES = {ssh_pkg::NBYTES{1'b1}};
   localparam int unsigned BAW = ssh_pkg::MEM_AW - 1;

   // ================================================================
   // storage
   ssh_pkg::ssh_word_t mem [ssh_pkg::MEM_DEPTH];

   // ================================================================
   // pll bypass pin, three-stage sync on k
   logic byp_s1_r, byp_s2_r, byp_s3_r;
   logic pll_on_r;
   logic lock_done_r;
   logic [ssh_pkg::LOCK_W-1:0] lock_cnt_r;

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         byp_s1_r <= 1'b0;
         byp_s2_r <= 1'b0;
         byp_s3_r <= 1'b0;
      end else begin
         byp_s1_r <= lnk.pll_bypass_n;
         byp_s2_r <= byp_s1_r;
         byp_s3_r <= byp_s2_r;
      end
   end

   // a level change counts once the later stages agree
   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         pll_on_r <= 1'b0;
      end else if (byp_s2_r == byp_s3_r) begin
         pll_on_r <= byp_s3_r;
      end
   end

   // pll needs a settle time after being enabled; bypass needs none
   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         lock_cnt_r <= '0;
      end else if (!pll_on_r) begin
         lock_cnt_r <= '0;
      end else if (!lock_done_r) begin
         lock_cnt_r <= lock_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         lock_done_r <= 1'b0;
      end else if (!pll_on_r) begin
         lock_done_r <= 1'b0;
      end else if (!lock_done_r) begin
         lock_done_r <= (lock_cnt_r == ssh_pkg::PLL_LOCK_CYC - 1'b1);
      end
   end

   assign pll_active = pll_on_r;
   assign pll_ready = !pll_on_r || lock_done_r;

   // ================================================================
   // read command path, k domain
   logic rd_go;
   logic rd_req1_r, rd_req2_r;
   ssh_pkg::ssh_addr_t rd_addr_r;

   // reads are ignored, not held, until the clocking path is usable
   assign rd_go = !lnk.rd_sel_n && pll_ready;

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         rd_req1_r <= 1'b0;
         rd_req2_r <= 1'b0;
      end else begin
         rd_req1_r <= rd_go;
         rd_req2_r <= rd_req1_r;
      end
   end

   // address held over idle slots
   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         rd_addr_r <= '0;
      end else if (rd_go) begin
         rd_addr_r <= lnk.shared_addr_lines;
      end
   end

   // ================================================================
   // array fetch one cycle after the read is taken
   ssh_pkg::ssh_word_t fetch0_r, fetch1_r;

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         fetch0_r <= '0;
         fetch1_r <= '0;
      end else if (rd_req1_r) begin
         fetch0_r <= mem[{rd_addr_r[BAW-1:0], 1'b0}];
         fetch1_r <= mem[{rd_addr_r[BAW-1:0], 1'b1}];
      end
   end

   // ================================================================
   // output launch: word 0 from k, word 1 from /k
   logic out_act_r, oe1_r, output_valid_flag_r;
   ssh_pkg::ssh_word_t q0_r, q1_hold_r, q1_r;

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         out_act_r <= 1'b0;
      end else begin
         out_act_r <= rd_req2_r;
      end
   end

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         q0_r <= '0;
         q1_hold_r <= '0;
      end else if (rd_req2_r) begin
         q0_r <= fetch0_r;
         q1_hold_r <= fetch1_r;
      end
   end

   // second half of the burst drives from the /k side
   always_ff @(posedge lnk.in_clk_n or negedge nrst) begin
      if (!nrst) begin
         oe1_r <= 1'b0;
      end else begin
         oe1_r <= out_act_r;
      end
   end

   always_ff @(posedge lnk.in_clk_n or negedge nrst) begin
      if (!nrst) begin
         q1_r <= '0;
      end else begin
         q1_r <= q1_hold_r;
      end
   end

   // flag rises at /k before word 0, falls at /k before the end
   always_ff @(posedge lnk.in_clk_n or negedge nrst) begin
      if (!nrst) begin
         output_valid_flag_r <= 1'b0;
      end else begin
         output_valid_flag_r <= rd_req2_r;
      end
   end

   // output bus released whenever no word is launched
   assign lnk.rd_data = lnk.in_clk ? q0_r : q1_r;
   assign lnk.rd_data_oe = lnk.in_clk ? out_act_r : oe1_r;
   assign lnk.output_valid_flag = output_valid_flag_r;

   // ================================================================
   // echo clocks follow the input pair without ever stopping
   assign lnk.echo_strobe = lnk.in_clk;
   assign lnk.echo_strobe_n = lnk.in_clk_n;

   // ================================================================
   // write path: word 0 and strobes at k, address and word 1 at /k
   logic wr_pend_r;
   ssh_pkg::ssh_word_t wr_w0_r;
   ssh_pkg::ssh_bmask_t wr_bs0_r;

   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= !lnk.wr_sel_n;
      end
   end

   // first word and its strobes held until the /k commit
   always_ff @(posedge lnk.in_clk or negedge nrst) begin
      if (!nrst) begin
         wr_w0_r <= '0;
         wr_bs0_r <= NO_BYTES;
      end else if (!lnk.wr_sel_n) begin
         wr_w0_r <= lnk.wr_data;
         wr_bs0_r <= lnk.byte_strobe_n;
      end
   end

   // commit both words at /k, byte by byte
   always_ff @(posedge lnk.in_clk_n) begin
      if (wr_pend_r) begin
         mem[{lnk.shared_addr_lines[BAW-1:0], 1'b0}] <= ssh_pkg::byte_merge(
            mem[{lnk.shared_addr_lines[BAW-1:0], 1'b0}], wr_w0_r, wr_bs0_r);
         mem[{lnk.shared_addr_lines[BAW-1:0], 1'b1}] <= ssh_pkg::byte_merge(
            mem[{lnk.shared_addr_lines[BAW-1:0], 1'b1}], lnk.wr_data, lnk.byte_strobe_n);
      end
   end
endmodule // ssh_sram_dev
`default_nettype wire

/* File: verification/ssh_link_properties.sv */
// concurrent checks on the link between controller end and sram end
`timescale 1ns/10ps
`default_nettype none
module ssh_link_properties (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic in_clk,
   input wire logic in_clk_n,
   input wire logic rd_sel_n,
   input wire logic wr_sel_n,
   input wire logic pll_bypass_n,
   input wire logic rd_data_oe,
   input wire logic output_valid_flag,
   input wire logic echo_strobe,
   input wire logic echo_strobe_n,
   input wire logic pll_ready
);
   // ==========================================================
   // echo clocks
   a_echo_toggles: assert property (@(posedge core_clk) disable iff (!nrst)
      1'b1 |-> ##[1:2] $changed(echo_strobe)) else $error("echo clock stalled");
   a_echo_pair: assert property (@(posedge core_clk) disable iff (!nrst)
      echo_strobe == in_clk && echo_strobe_n != echo_strobe) else $error("echo pair wrong");
   // ==========================================================
   // read pipeline and bypass readiness, sampled at k
   a_read_oe: assert property (@(posedge in_clk) disable iff (!nrst)
      !rd_sel_n && pll_ready |-> ##3 rd_data_oe) else $error("read data not driven");
   a_read_flag: assert property (@(posedge in_clk) disable iff (!nrst)
      !rd_sel_n && pll_ready |-> ##2 output_valid_flag) else $error("valid flag missing");
   a_flag_cause: assert property (@(posedge in_clk) disable iff (!nrst)
      output_valid_flag |-> $past(rd_sel_n, 2) == 1'b0) else $error("flag without read");
   a_flag_leads: assert property (@(posedge in_clk) disable iff (!nrst)
      $rose(output_valid_flag) |=> rd_data_oe) else $error("flag does not lead data");
   a_flag_drop: assert property (@(posedge in_clk) disable iff (!nrst)
      $fell(output_valid_flag) |-> rd_data_oe) else $error("flag drop not before data end");
   a_nop_quiet: assert property (@(posedge in_clk) disable iff (!nrst)
      rd_sel_n |-> ##3 !rd_data_oe) else $error("outputs driven without read");
   a_bypass_ready: assert property (@(posedge in_clk) disable iff (!nrst)
      !pll_bypass_n [*5] |-> pll_ready) else $error("bypass not ready");
   // ==========================================================
   // scenario coverage
   c_read: cover property (@(posedge in_clk) !rd_sel_n && pll_ready);
   c_write: cover property (@(posedge in_clk) !wr_sel_n);
   c_dual: cover property (@(posedge in_clk) !wr_sel_n && !rd_sel_n);
endmodule // ssh_link_properties
`default_nettype wire

/* File: verification/sync_sram_host_port_tb.sv */
// self-checking bench: controller end and sram end joined over the link
`timescale 1ns/10ps
`default_nettype none
module sync_sram_host_port_tb;
   typedef ssh_pkg::ssh_word_t ssh_w_t;
   typedef ssh_pkg::ssh_addr_t ssh_a_t;
   typedef ssh_pkg::ssh_bmask_t ssh_b_t;
   logic core_clk, nrst, pll_bypass_req, rd_valid, wr_valid, req_ready, rsp_valid, pll_active, pll_ready;
   ssh_a_t rd_addr, wr_addr;
   ssh_w_t wr_data0, wr_data1, rsp_data0, rsp_data1;
   ssh_b_t wr_be0, wr_be1;
   int err_count, cmp_count;
   ssh_a_t addrs [4] = '{21'h00_0000, 21'h00_0001, 21'h00_00aa, 21'h00_01ff};
   ssh_link_if lnk ();
   ssh_sram_ctl u_ssh_sram_ctl (.lnk(lnk), .core_clk(core_clk), .nrst(nrst), .pll_bypass_req(pll_bypass_req),
      .rd_valid(rd_valid), .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data0(wr_data0),
      .wr_data1(wr_data1), .wr_be0(wr_be0), .wr_be1(wr_be1), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data0(rsp_data0), .rsp_data1(rsp_data1));
   ssh_sram_dev u_ssh_sram_dev (.lnk(lnk), .nrst(nrst), .pll_active(pll_active), .pll_ready(pll_ready));
   ssh_link_properties u_ssh_link_properties (.core_clk(core_clk), .nrst(nrst), .in_clk(lnk.in_clk),
      .in_clk_n(lnk.in_clk_n), .rd_sel_n(lnk.rd_sel_n), .wr_sel_n(lnk.wr_sel_n),
      .pll_bypass_n(lnk.pll_bypass_n), .rd_data_oe(lnk.rd_data_oe), .output_valid_flag(lnk.output_valid_flag),
      .echo_strobe(lnk.echo_strobe), .echo_strobe_n(lnk.echo_strobe_n), .pll_ready(pll_ready));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ==========================================================
   // helpers
   function automatic ssh_w_t wd(int i, int w);
      return 36'h5_a3c9_0f00 + 36'(i * 16 + w);
   endfunction
   function automatic ssh_w_t mrg(ssh_w_t o, ssh_w_t n, ssh_b_t be);
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            o[b*9 +: 9] = n[b*9 +: 9];
         end
      end
      return o;
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(logic ok, string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic do_reset(logic byp);
      @(posedge core_clk);
      nrst <= 1'b0;
      pll_bypass_req <= byp;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
   endtask
   // one request slot; caller stands just after a clock edge
   task automatic issue(logic rd, logic wr, ssh_a_t ra, ssh_a_t wa, ssh_w_t d0, ssh_w_t d1, ssh_b_t b0, ssh_b_t b1);
      logic taken;
      taken = 1'b0;
      @(posedge core_clk);
      rd_valid <= rd;
      wr_valid <= wr;
      rd_addr <= ra;
      wr_addr <= wa;
      wr_data0 <= d0;
      wr_data1 <= d1;
      wr_be0 <= b0;
      wr_be1 <= b1;
      for (int n = 0; n < 8 && !taken; n++) begin
         #1;
         taken = (req_ready === 1'b1);
         @(posedge core_clk);
      end
      rd_valid <= 1'b0;
      wr_valid <= 1'b0;
      check(taken, "request not taken");
      if (!taken) begin
         summarize();
      end
   endtask
   task automatic await_rsp(logic exp_rsp, ssh_w_t e0, ssh_w_t e1);
      int n;
      n = 0;
      while (n < 16 && rsp_valid !== 1'b1) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 16 && exp_rsp) begin
         check(1'b0, "no read response");
         summarize();
      end else begin
         check(exp_rsp ? n == 12 : n == 16, "response timing");
         if (exp_rsp) begin
            check(rsp_data0 === e0 && rsp_data1 === e1, "read data mismatch");
         end
      end
   endtask
   task automatic wr(ssh_a_t a, ssh_w_t d0, ssh_w_t d1, ssh_b_t b0, ssh_b_t b1);
      issue(1'b0, 1'b1, '0, a, d0, d1, b0, b1);
   endtask
   task automatic rd(ssh_a_t a, ssh_w_t e0, ssh_w_t e1);
      issue(1'b1, 1'b0, a, '0, '0, '0, '0, '0);
      await_rsp(1'b1, e0, e1);
   endtask

   // ==========================================================
   // scenarios
   task automatic s_basic();
      for (int i = 0; i < 4; i++) begin
         wr(addrs[i], wd(i, 0), wd(i, 1), 4'hf, 4'hf);
      end
      for (int i = 3; i >= 0; i--) begin
         rd(addrs[i], wd(i, 0), wd(i, 1));
      end
   endtask
   task automatic s_mask();
      ssh_a_t a;
      a = 21'h00_0020;
      wr(a, 36'h1_1111_1111, 36'h2_2222_2222, 4'hf, 4'hf);
      wr(a, 36'hf_ffff_ffff, 36'hf_ffff_ffff, 4'h0, 4'h0);
      wr(a, 36'ha_bcde_f012, 36'h3_4567_89ab, 4'h5, 4'ha);
      rd(a, mrg(36'h1_1111_1111, 36'ha_bcde_f012, 4'h5), mrg(36'h2_2222_2222, 36'h3_4567_89ab, 4'ha));
   endtask
   task automatic s_dual();
      issue(1'b1, 1'b1, addrs[1], 21'h00_0030, 36'h0_dead_0001, 36'h0_dead_0002, 4'hf, 4'hf);
      await_rsp(1'b1, wd(1, 0), wd(1, 1));
      rd(21'h00_0030, 36'h0_dead_0001, 36'h0_dead_0002);
   endtask
   task automatic s_idle();
      int flips;
      logic last;
      flips = 0;
      last = lnk.echo_strobe;
      for (int n = 0; n < 40; n++) begin
         @(posedge core_clk);
         #1;
         flips += (lnk.echo_strobe !== last);
         last = lnk.echo_strobe;
         check(lnk.rd_data_oe === 1'b0 && rsp_valid === 1'b0, "idle outputs active");
      end
      check(flips == 20, "echo clock count");
   endtask
   task automatic s_pll();
      int n;
      do_reset(1'b0);
      repeat (24) @(posedge core_clk);
      #1;
      check(pll_active === 1'b1 && pll_ready === 1'b0, "pll not locking");
      issue(1'b1, 1'b0, addrs[2], '0, '0, '0, '0, '0);
      await_rsp(1'b0, '0, '0);
      n = 0;
      while (n < 1200 && pll_ready !== 1'b1) begin
         @(posedge core_clk);
         n++;
      end
      check(n < 1200, "pll never ready");
      if (n >= 1200) begin
         summarize();
      end
      rd(addrs[2], wd(2, 0), wd(2, 1));
      @(posedge core_clk);
      pll_bypass_req <= 1'b1;
      repeat (24) @(posedge core_clk);
      #1;
      check(pll_active === 1'b0 && pll_ready === 1'b1, "bypass not taken");
   endtask

   initial begin
      err_count = 0;
      cmp_count = 0;
      nrst = 1'b0;
      pll_bypass_req = 1'b1;
      rd_valid = 1'b0;
      wr_valid = 1'b0;
      rd_addr = '0;
      wr_addr = '0;
      wr_data0 = '0;
      wr_data1 = '0;
      wr_be0 = '0;
      wr_be1 = '0;
      do_reset(1'b1);
      repeat (4) @(posedge core_clk);
      s_basic();
      s_mask();
      s_dual();
      s_idle();
      s_pll();
      summarize();
   end
endmodule // sync_sram_host_port_tb
`default_nettype wire
